/* File: inc/cli_map.svh */
/*
  Offsets, field widths, reset values and timing counts of the cold-load and
  inrush detector. Assumes a 100 MHz clock and a 32-bit register port.
*/
`ifndef CLI_MAP_SVH
`define CLI_MAP_SVH

`define CLI_CLK_MHZ 100
`define CLI_RISE_MS 80
`define CLI_RISE_CYC (`CLI_RISE_MS * 1000 * `CLI_CLK_MHZ)
`define CLI_CYC_PER_MS (1000 * `CLI_CLK_MHZ)
`define CLI_ADDR_W 4
`define CLI_CUR_W 16

`define CLI_REG_CTRL 4'h0
`define CLI_REG_IDLE 4'h1
`define CLI_REG_PICKUP 4'h2
`define CLI_REG_HOLD 4'h3
`define CLI_REG_F2THR 4'h4
`define CLI_REG_STATUS 4'h5
`define CLI_REG_LARGEST 4'h6
`define CLI_REG_IRQ 4'h7
`define CLI_REG_MASK 4'h8
`define CLI_REG_PRIM_IDLE 4'h9
`define CLI_REG_PRIM_PICK 4'hA
`define CLI_REG_CTSCALE 4'hB

`define CLI_RST_IDLE 16'h0080
`define CLI_RST_PICKUP 16'h0200
`define CLI_RST_HOLD 16'h03E8
`define CLI_RST_F2THR 8'h00
`define CLI_RST_CTSCALE 16'h0100
`define CLI_PU_FRAC 8

`define CLI_IRQ_CL_START 0
`define CLI_IRQ_CL_TRIP 1
`define CLI_IRQ_IN_START 2
`define CLI_IRQ_IN_TRIP 3
`define CLI_IRQ_W 4

`define CLI_PCT_FULL 32'd100
`define CLI_ST_CL_TRIP 0
`define CLI_ST_CL_START 1
`define CLI_ST_IN_TRIP 2
`define CLI_ST_IN_START 3
`define CLI_ST_PW 5

`endif

/* File: inc/cli_pkg.sv */
/*
  Types of the cold-load and inrush detector. Field widths come from the map header.
*/
`include "cli_map.svh"
package cli_pkg;
  typedef struct packed {
    logic [`CLI_CUR_W-1:0] fund;
    logic [`CLI_CUR_W-1:0] harm2;
  } cli_phase_s;

  typedef struct packed {
    logic start;
    logic trip;
  } cli_status_s;

  typedef enum logic [1:0] {CLI_NOT_IDLE, CLI_IDLE, CLI_WINDOW} cli_arm_e;
endpackage

/* File: rtl/cli_detector.sv */
/*
  Cold-load pick-up and magnetising inrush detector: three phase magnitudes in,
  detection, blocking and status out, settings over a plain register port.
  Assumes the measurement path delivers fund/harm2 per phase with a tick strobe,
  and that one full power cycle has been analysed when cycleDone pulses.
*/
// Local design decisions: the strobed register port and the register offsets.
// Overview of operation
// - Idle all phases, then pick-up within 80 ms
// - Cold-load output held for hold duration
// - Both outputs feed output and blocking matrices; code puts inrushBlock, not inrushOut, into the blocking matrix
// - Inrush needs rise plus second-harmonic ratio
// - Zero harmonic threshold makes inrush equal cold-load
// - Inrush blocking asserts at current rise
// - After first cycle keep blocking only if harmonic
// - Status start while active, trip on timeout
// - Report largest of three phase magnitudes
// - Output held for time or while above pick-up
// - Rise slower than 80 ms never detects
// - No detection without prior idle condition
// - Report idle and pick-up in primary amperes
// - Harmonic threshold held as percent ratio
// - Settings writable only with valid password
`timescale 1ns/10ps
`include "cli_map.svh"
module cli_detector (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Measurement path
  input wire logic tick,
  input wire logic cycleDone,
  input wire cli_pkg::cli_phase_s phaseCurrentA,
  input wire cli_pkg::cli_phase_s phaseCurrentB,
  input wire cli_pkg::cli_phase_s phaseCurrentC,
  // Parameter store
  input wire logic passwordValid,
  // Register port
  input wire logic [`CLI_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Matrices
  output logic coldLoadOut,
  output logic inrushOut,
  output logic inrushBlock,
  output logic [1:0] outputMatrix,
  output logic [1:0] blockingMatrix,
  output logic irq
);

  logic [`CLI_CUR_W-1:0] idleLimit;
  logic [`CLI_CUR_W-1:0] pickupLevel;
  logic [`CLI_CUR_W-1:0] holdDuration;
  logic [7:0] secondHarmonicThreshold;
  logic [`CLI_CUR_W-1:0] ctScale;
  logic enable;
  logic [`CLI_CUR_W-1:0] largestPhaseCurrent;
  logic [`CLI_IRQ_W-1:0] irqStatus;
  logic [`CLI_IRQ_W-1:0] irqMask;
  cli_pkg::cli_arm_e armState;
  logic [31:0] windowCnt;
  logic [31:0] msCnt;
  logic [`CLI_CUR_W-1:0] holdMs;
  logic clActive;
  logic inActive;
  logic harmSeen;
  logic cycleSeen;
  cli_pkg::cli_status_s coldLoadState;
  cli_pkg::cli_status_s inrushState;
  logic [2:0] allIdle;
  logic [2:0] abovePick;
  logic [2:0] harmHigh;
  logic [`CLI_CUR_W-1:0] fundArr [3];
  logic [`CLI_CUR_W-1:0] harmArr [3];
  logic riseDetect;
  logic anyHarm;
  logic anyAbove;
  logic clEnd;
  logic [`CLI_IRQ_W-1:0] irqEvent;
  logic [31:0] next_regRdata;
  logic [31:0] primIdle;
  logic [31:0] primPick;
  logic [31:0] statusWord;
  logic zeroThreshold;

  assign fundArr[0] = phaseCurrentA.fund;
  assign fundArr[1] = phaseCurrentB.fund;
  assign fundArr[2] = phaseCurrentC.fund;
  assign harmArr[0] = phaseCurrentA.harm2;
  assign harmArr[1] = phaseCurrentB.harm2;
  assign harmArr[2] = phaseCurrentC.harm2;

  // Per-phase comparisons; ratio test avoids a divider: 100*h2 > thr*f1
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gPhase
      assign allIdle[gi] = fundArr[gi] < idleLimit;
      assign abovePick[gi] = fundArr[gi] > pickupLevel;
      assign harmHigh[gi] = (32'(harmArr[gi]) * `CLI_PCT_FULL) > (32'(fundArr[gi]) * 32'(secondHarmonicThreshold));
    end
  endgenerate

  assign anyAbove = |abovePick;
  assign zeroThreshold = (secondHarmonicThreshold == 8'h00);
  assign anyHarm = zeroThreshold || (|harmHigh);
  assign riseDetect = enable && tick && anyAbove && (armState != cli_pkg::CLI_NOT_IDLE)
    && !(&allIdle);

  // Refreshed on ticks only, so it shows the last evaluated set
  // Largest phase magnitude
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      largestPhaseCurrent <= 16'h0000;
    end else if (tick) begin
      largestPhaseCurrent <= (fundArr[0] > fundArr[1]) ?
        ((fundArr[0] > fundArr[2]) ? fundArr[0] : fundArr[2]) :
        ((fundArr[1] > fundArr[2]) ? fundArr[1] : fundArr[2]);
    end
  end

  // Idle is tracked while disabled, so enabling arms at once
  // Window arming
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      armState <= cli_pkg::CLI_NOT_IDLE;
      windowCnt <= 32'h0000_0000;
    end else begin
      // Saturates so a long linger never wraps back into the window
      if (armState == cli_pkg::CLI_WINDOW && windowCnt < `CLI_RISE_CYC) begin
        windowCnt <= windowCnt + 32'h0000_0001;
      end
      if (tick) begin
        unique case (armState)
          cli_pkg::CLI_NOT_IDLE: begin
            if (&allIdle) begin
              armState <= cli_pkg::CLI_IDLE;
            end
          end
          cli_pkg::CLI_IDLE: begin
            if (!(&allIdle)) begin
              armState <= anyAbove ? cli_pkg::CLI_NOT_IDLE : cli_pkg::CLI_WINDOW;
              windowCnt <= 32'h0000_0000;
            end
          end
          cli_pkg::CLI_WINDOW: begin
            if (&allIdle) begin
              armState <= cli_pkg::CLI_IDLE;
            end else if (anyAbove || windowCnt >= `CLI_RISE_CYC) begin
              armState <= cli_pkg::CLI_NOT_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Rise counts if window still open; a rise straight from idle counts too
  logic riseOk;
  assign riseOk = riseDetect && (armState == cli_pkg::CLI_IDLE || windowCnt < `CLI_RISE_CYC);

  // Millisecond prescaler for the hold timer
  // Saturating hold count keeps a huge hold from wrapping
  always_ff @(posedge clk) begin
    if (sys_rst || !clActive) begin
      msCnt <= 32'h0000_0000;
      holdMs <= 16'h0000;
    end else if (msCnt == `CLI_CYC_PER_MS - 1) begin
      msCnt <= 32'h0000_0000;
      if (holdMs != 16'hFFFF) begin
        holdMs <= holdMs + 16'h0001;
      end
    end else begin
      msCnt <= msCnt + 32'h0000_0001;
    end
  end

  // Inputs hold between ticks, so the end may fall between ticks
  // Ends after time and below pick-up
  assign clEnd = clActive && (holdMs >= holdDuration) && !anyAbove;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clActive <= 1'b0;
      coldLoadState <= '0;
    end else begin
      if (riseOk) begin
        clActive <= 1'b1;
        coldLoadState <= '{start: 1'b1, trip: 1'b0};
      end else if (clEnd) begin
        clActive <= 1'b0;
        coldLoadState <= '{start: 1'b0, trip: 1'b1};
      end
    end
  end

  // Block at rise, decide after first cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cycleSeen <= 1'b0;
      harmSeen <= 1'b0;
      inActive <= 1'b0;
      inrushState <= '0;
    end else begin
      if (riseOk) begin
        cycleSeen <= 1'b0;
        harmSeen <= 1'b0;
        inActive <= 1'b1;
        inrushState <= '{start: 1'b1, trip: 1'b0};
      end else if (inActive && cycleDone && !cycleSeen) begin
        // Only the first cycle result counts; later ones are ignored
        cycleSeen <= 1'b1;
        harmSeen <= anyHarm;
        if (!anyHarm) begin
          inActive <= 1'b0;
          inrushState <= '0;
        end
      end else if (clEnd && inActive) begin
        inActive <= 1'b0;
        inrushState <= '{start: 1'b0, trip: 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      coldLoadOut <= 1'b0;
      inrushOut <= 1'b0;
      inrushBlock <= 1'b0;
    end else begin
      coldLoadOut <= clActive;
      // Zero threshold follows cold-load at once
      inrushOut <= inActive && (zeroThreshold || (cycleSeen && harmSeen));
      inrushBlock <= inActive;
    end
  end

  assign outputMatrix = {inrushOut, coldLoadOut};
  assign blockingMatrix = {inrushBlock, coldLoadOut};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable <= 1'b0;
      idleLimit <= `CLI_RST_IDLE;
      pickupLevel <= `CLI_RST_PICKUP;
      holdDuration <= `CLI_RST_HOLD;
      secondHarmonicThreshold <= `CLI_RST_F2THR;
      ctScale <= `CLI_RST_CTSCALE;
    end else if (regWr && passwordValid) begin
      unique case (regAddr)
        `CLI_REG_CTRL: enable <= regWdata[0];
        `CLI_REG_IDLE: idleLimit <= regWdata[`CLI_CUR_W-1:0];
        `CLI_REG_PICKUP: pickupLevel <= regWdata[`CLI_CUR_W-1:0];
        `CLI_REG_HOLD: holdDuration <= regWdata[`CLI_CUR_W-1:0];
        `CLI_REG_F2THR: secondHarmonicThreshold <= regWdata[7:0];
        `CLI_REG_CTSCALE: ctScale <= regWdata[`CLI_CUR_W-1:0];
        default: ;
      endcase
    end
  end

  // Interrupt mask and clear are not settings, so need no password
  // Sticky interrupt events; set wins over write-one-to-clear
  assign irqEvent[`CLI_IRQ_CL_START] = riseOk;
  assign irqEvent[`CLI_IRQ_CL_TRIP] = clEnd;
  assign irqEvent[`CLI_IRQ_IN_START] = riseOk;
  assign irqEvent[`CLI_IRQ_IN_TRIP] = clEnd && inActive;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStatus <= '0;
      irqMask <= '0;
    end else begin
      if (regWr && regAddr == `CLI_REG_MASK) begin
        irqMask <= regWdata[`CLI_IRQ_W-1:0];
      end
      if (regWr && regAddr == `CLI_REG_IRQ) begin
        irqStatus <= (irqStatus & ~regWdata[`CLI_IRQ_W-1:0]) | irqEvent;
      end else begin
        irqStatus <= irqStatus | irqEvent;
      end
    end
  end
  assign irq = |(irqStatus & irqMask);

  // 16-bit settings times 16-bit scale stay inside 32 bits
  // Primary ampere scaling
  assign primIdle = (32'(idleLimit) * 32'(ctScale)) >> `CLI_PU_FRAC;
  assign primPick = (32'(pickupLevel) * 32'(ctScale)) >> `CLI_PU_FRAC;

  // Status word: password, inrush start/trip, cold-load start/trip
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`CLI_ST_PW] = passwordValid;
    statusWord[`CLI_ST_IN_START] = inrushState.start;
    statusWord[`CLI_ST_IN_TRIP] = inrushState.trip;
    statusWord[`CLI_ST_CL_START] = coldLoadState.start;
    statusWord[`CLI_ST_CL_TRIP] = coldLoadState.trip;
  end

  always_comb begin
    next_regRdata = 32'h0000_0000;
    unique case (regAddr)
      `CLI_REG_CTRL: next_regRdata = {31'h0, enable};
      `CLI_REG_IDLE: next_regRdata = {16'h0, idleLimit};
      `CLI_REG_PICKUP: next_regRdata = {16'h0, pickupLevel};
      `CLI_REG_HOLD: next_regRdata = {16'h0, holdDuration};
      `CLI_REG_F2THR: next_regRdata = {24'h0, secondHarmonicThreshold};
      `CLI_REG_STATUS: next_regRdata = statusWord;
      `CLI_REG_LARGEST: next_regRdata = {16'h0, largestPhaseCurrent};
      `CLI_REG_IRQ: next_regRdata = {28'h0, irqStatus};
      `CLI_REG_MASK: next_regRdata = {28'h0, irqMask};
      `CLI_REG_PRIM_IDLE: next_regRdata = primIdle;
      `CLI_REG_PRIM_PICK: next_regRdata = primPick;
      `CLI_REG_CTSCALE: next_regRdata = {16'h0, ctScale};
      default: next_regRdata = 32'h0000_0000;
    endcase
  end

  // Zero outside the read slot keeps a shared read bus quiet
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= regRd ? next_regRdata : 32'h0000_0000;
    end
  end

endmodule // cli_detector

/* File: verification/cli_detector_checker.sv */
/* Port assertions of the detector. Assumes a bind from the bench top. */
`timescale 1ns/10ps
module cli_detector_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Observed
  input wire logic tick,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic coldLoadOut,
  input wire logic inrushOut,
  input wire logic inrushBlock,
  input wire logic [1:0] outputMatrix,
  input wire logic [1:0] blockingMatrix
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_out_matrix: assert property (outputMatrix == {inrushOut, coldLoadOut})
    else $error("output matrix mismatch");
  a_block_matrix: assert property (blockingMatrix == {inrushBlock, coldLoadOut})
    else $error("blocking matrix mismatch");
  a_read_quiet: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read slot");
  a_reset_clear: assert property ($past(sys_rst) |-> !coldLoadOut && !inrushOut && !inrushBlock)
    else $error("output high after reset");
  a_tick_cause: assert property ($rose(coldLoadOut) |-> $past(tick, 2))
    else $error("detection not two cycles after tick");
  a_block_at_rise: assert property ($rose(coldLoadOut) |-> inrushBlock)
    else $error("blocking missing at rise");
  a_block_cause: assert property ($rose(inrushBlock) |-> $rose(coldLoadOut))
    else $error("blocking without rise");
  a_inrush_needs_rise: assert property ($rose(inrushOut) |-> coldLoadOut)
    else $error("inrush without cold load");
  a_inrush_keeps_block: assert property ($rose(inrushOut) |-> inrushBlock)
    else $error("inrush without blocking");
endmodule // cli_detector_checker

/* File: verification/cli_meas_model.sv */
/* Measurement path model: phase magnitudes per tick. Assumes bench calls tasks. */
`timescale 1ns/10ps
module cli_meas_model (
  // Clock
  input wire logic clk,
  // Measurement stream
  output logic tick,
  output logic cycleDone,
  output cli_pkg::cli_phase_s phA,
  output cli_pkg::cli_phase_s phB,
  output cli_pkg::cli_phase_s phC
);
  initial begin
    tick = 1'b0;
    cycleDone = 1'b0;
    phA = '0;
    phB = '0;
    phC = '0;
  end
  task automatic sample(input logic [15:0] fa, input logic [15:0] fb, input logic [15:0] fc, input int pct);
    @(posedge clk);
    tick <= 1'b1;
    phA <= {fa, 16'(fa * pct / 100)};
    phB <= {fb, 16'(fb * pct / 100)};
    phC <= {fc, 16'(fc * pct / 100)};
    @(posedge clk);
    tick <= 1'b0;
  endtask
  task automatic done();
    @(posedge clk);
    cycleDone <= 1'b1;
    @(posedge clk);
    cycleDone <= 1'b0;
  endtask
endmodule // cli_meas_model

/* File: verification/test_cli_detector.sv */
/* Self-checking bench of the detector. Assumes the map header on the path. */
`timescale 1ns/10ps
`include "cli_map.svh"
module test_cli_detector;
  logic clk, sys_rst, passwordValid, regWr, regRd, tick, cycleDone;
  logic coldLoadOut, inrushOut, inrushBlock, irq;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata, largest;
  logic [1:0] outputMatrix, blockingMatrix;
  logic [3:0] expStat;
  cli_pkg::cli_phase_s phA, phB, phC;
  int numErrors = 0, checkCount = 0, cycles = 0;
  int expReg [16];
  logic [15:0] f [3];

  cli_meas_model u_cli_meas_model (.clk(clk), .tick(tick), .cycleDone(cycleDone), .phA(phA), .phB(phB), .phC(phC));
  cli_detector u_cli_detector (.clk(clk), .sys_rst(sys_rst), .tick(tick), .cycleDone(cycleDone),
    .phaseCurrentA(phA), .phaseCurrentB(phB), .phaseCurrentC(phC), .passwordValid(passwordValid),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .coldLoadOut(coldLoadOut), .inrushOut(inrushOut), .inrushBlock(inrushBlock),
    .outputMatrix(outputMatrix), .blockingMatrix(blockingMatrix), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic endSim();
    if (numErrors == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      numErrors++;
      endSim();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Settings need the password, mask does not
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    if ((passwordValid && a < 4'hC && a != 4'h7) || a == 4'h8) expReg[a] = d;
  endtask

  function automatic logic [31:0] expRd(input int a);
    case (a)
      5: return {26'h0, passwordValid, 1'b0, expStat};
      6: return largest;
      9: return (expReg[1] * expReg[11]) >> 8;
      10: return (expReg[2] * expReg[11]) >> 8;
      default: return expReg[a];
    endcase
  endfunction

  task automatic rdChk(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check($sformatf("reg %h", a), regRdata, expRd(a));
  endtask

  task automatic rdAll();
    for (int a = 0; a < 16; a++) rdChk(4'(a));
  endtask

  task automatic outs(input string what, input logic [2:0] exp);
    repeat (6) @(posedge clk);
    #1 check(what, {29'h0, inrushBlock, inrushOut, coldLoadOut}, {29'h0, exp});
    check({what, " out matrix"}, {30'h0, outputMatrix}, {30'h0, exp[1:0]});
    check({what, " block matrix"}, {30'h0, blockingMatrix}, {30'h0, exp[2], exp[0]});
  endtask

  // Idle tick then a rise on phase b with the given harmonic percent
  task automatic energise(input int pct);
    u_cli_meas_model.sample(16'h0, 16'h0, 16'h0, 0);
    u_cli_meas_model.sample(16'h0, 16'h400, 16'h0, pct);
  endtask

  initial begin
    sys_rst = 1'b1;
    passwordValid = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h0;
    largest = 32'h0;
    expStat = 4'h0;
    expReg = '{default: 0};
    expReg[1] = `CLI_RST_IDLE;
    expReg[2] = `CLI_RST_PICKUP;
    expReg[3] = `CLI_RST_HOLD;
    expReg[11] = `CLI_RST_CTSCALE;
    void'($urandom(25678));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rdAll();
    passwordValid <= 1'b0;
    wr(4'h2, 32'h300);
    wr(4'hB, 32'h200);
    passwordValid <= 1'b1;
    rdAll();
    wr(4'hB, 32'h200);
    wr(4'h1, 32'h90);
    wr(4'h3, 32'h0);
    wr(4'h0, 32'h1);
    rdAll();
    repeat (3) begin
      foreach (f[i]) f[i] = 16'h100 + 16'($urandom % 256);
      u_cli_meas_model.sample(f[0], f[1], f[2], 0);
      largest = 32'(f[0] > f[1] ? (f[0] > f[2] ? f[0] : f[2]) : (f[1] > f[2] ? f[1] : f[2]));
      rdChk(4'h6);
    end
    u_cli_meas_model.sample(16'h400, 16'h100, 16'h100, 0);
    outs("no idle", 3'b000);
    wr(4'h0, 32'h0);
    energise(0);
    outs("disabled", 3'b000);
    wr(4'h0, 32'h1);
    u_cli_meas_model.sample(16'h100, 16'h100, 16'h100, 0);
    wr(4'h8, 32'h0);
    energise(0);
    outs("cold load", 3'b111);
    check("masked irq", {31'h0, irq}, 32'h0);
    wr(4'h8, 32'h1);
    #1 check("irq", {31'h0, irq}, 32'h1);
    expStat = 4'b1010;
    rdChk(4'h5);
    u_cli_meas_model.done();
    outs("zero threshold", 3'b111);
    wr(4'h7, 32'hF);
    #1 check("irq clear", {31'h0, irq}, 32'h0);
    u_cli_meas_model.sample(16'h100, 16'h100, 16'h100, 0);
    outs("hold end", 3'b000);
    expStat = 4'b0101;
    rdChk(4'h5);
    wr(4'h4, 32'd20);
    energise(50);
    outs("rise", 3'b101);
    u_cli_meas_model.done();
    outs("inrush", 3'b111);
    u_cli_meas_model.sample(16'h100, 16'h100, 16'h100, 0);
    energise(5);
    outs("rise low", 3'b101);
    u_cli_meas_model.done();
    outs("release", 3'b001);
    endSim();
  end
endmodule // test_cli_detector

bind cli_detector cli_detector_checker u_cli_detector_checker (.clk(clk), .sys_rst(sys_rst), .tick(tick),
  .regRd(regRd), .regRdata(regRdata), .coldLoadOut(coldLoadOut), .inrushOut(inrushOut),
  .inrushBlock(inrushBlock), .outputMatrix(outputMatrix), .blockingMatrix(blockingMatrix));
